/* testbench/pwm_output_config_tb.sv */
// self-checking bench for the pwm output configuration stage
`timescale 1ns/100ps
`default_nettype none
module pwm_output_config_tb;
  // ---------------------------------------------------------------------------
  // signals and case table
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ind;
    logic [7:0] pol;
    logic [7:0] msk;
    logic [7:0] swp;
    logic [7:0] ce;
    logic [7:0] co;
    logic [7:0] exp;
  } poc_row_t;
  logic clk;
  logic rst_b;
  logic [poc_pkg::AW-1:0] addr;
  logic [poc_pkg::DW-1:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [poc_pkg::DW-1:0] rdata;
  poc_pkg::poc_word_array_t cnt;
  logic wait_mode;
  logic freeze_mode;
  logic [poc_pkg::NCH-1:0] pwm_out;
  int n_fail;
  int checks;
  int cycles;
  logic [7:0] bmask;
  // independent, polarity, mask, exchange, even and odd counters, expected outputs; values all 8'h40
  poc_row_t rows [12] = '{
    '{8'h07, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h3F}, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h41, 8'h41, 8'h00},
    '{8'h07, 8'h3F, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00}, '{8'h07, 8'h3F, 8'h00, 8'h00, 8'h41, 8'h41, 8'h3F},
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h15}, '{8'h00, 8'h00, 8'h00, 8'h07, 8'h10, 8'h10, 8'h2A},
    '{8'h07, 8'h00, 8'h00, 8'h07, 8'h10, 8'h50, 8'h15}, '{8'h01, 8'h00, 8'h00, 8'h07, 8'h10, 8'h50, 8'h29},
    '{8'h07, 8'h00, 8'h05, 8'h00, 8'h10, 8'h10, 8'h3A}, '{8'h00, 8'h3F, 8'h3F, 8'h00, 8'h10, 8'h10, 8'h3F},
    '{8'h07, 8'h01, 8'h03, 8'h00, 8'h10, 8'h10, 8'h3D}, '{8'h07, 8'h15, 8'h00, 8'h00, 8'h10, 8'h10, 8'h2A}};

  pwm_output_config i_dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .cnt(cnt), .wait_mode(wait_mode), .freeze_mode(freeze_mode), .pwm_out(pwm_out));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // bus, compare and closing tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data appear in the cycle after the strobe and hold until the next read strobe
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask : rdc

  task automatic outc(input string nm, input logic [7:0] exp);
    @(posedge clk);
    #1;
    chk(nm, {2'h0, pwm_out}, exp);
  endtask : outc

  task automatic set_cnt(input logic [7:0] ce, input logic [7:0] co);
    @(posedge clk);
    for (int i = 0; i < poc_pkg::NCH; i++) cnt[i] <= i[0] ? co : ce;
  endtask : set_cnt

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset outputs", {2'h0, pwm_out}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cnt = '0;
    wait_mode = 1'b0;
    freeze_mode = 1'b0;
    n_fail = 0;
    checks = 0;
    cycles = 0;
    do_reset();
    for (int a = 0; a < 4; a++) rdc("reset value", 8'(a), poc_pkg::RST_VAL);
    wr(poc_pkg::ADDR_CFG1, 8'h80);
    for (int m = 0; m < 4; m++) begin
      wr(poc_pkg::ADDR_CFG3, 8'h00);
      for (int k = 0; k < 6; k++) wr(poc_pkg::ADDR_VAL0 + 8'(k), 8'h00);
      wr(poc_pkg::ADDR_CFG3, 8'(m) << 3);
      wr(poc_pkg::ADDR_VAL0, 8'hA5);
      bmask = (m == 1) ? 8'h3F : ((m == 2) ? 8'h0F : 8'h01);
      for (int k = 0; k < 6; k++) rdc("value word", poc_pkg::ADDR_VAL0 + 8'(k), bmask[k] ? 8'hA5 : 8'h00);
    end
    wr(poc_pkg::ADDR_CFG3, 8'h00);
    wr(poc_pkg::ADDR_CFG1, 8'h00);
    wr(poc_pkg::ADDR_CFG3, 8'hDF);
    rdc("cfg3 gated", poc_pkg::ADDR_CFG3, 8'hC0);
    wr(poc_pkg::ADDR_CFG1, 8'h80);
    wr(poc_pkg::ADDR_CFG3, 8'hDF);
    rdc("cfg3 open", poc_pkg::ADDR_CFG3, 8'hDF);
    wr(poc_pkg::ADDR_CFG1, 8'h00);
    wr(poc_pkg::ADDR_CFG3, 8'h00);
    rdc("cfg3 kept", poc_pkg::ADDR_CFG3, 8'h1F);
    wr(poc_pkg::ADDR_CFG1, 8'hFF);
    rdc("cfg1 fields", poc_pkg::ADDR_CFG1, 8'hBF);
    wr(poc_pkg::ADDR_CFG2, 8'hFF);
    rdc("cfg2 fields", poc_pkg::ADDR_CFG2, 8'h3F);
    wr(poc_pkg::ADDR_CFG0, 8'h7F);
    rdc("cfg0 fields", poc_pkg::ADDR_CFG0, 8'h07);
    wr(8'h20, 8'hFF);
    rdc("unmapped", 8'h20, 8'h00);
    wr(poc_pkg::ADDR_CFG3, 8'h08);
    wr(poc_pkg::ADDR_VAL0, 8'h40);
    for (int i = 0; i < 12; i++) begin
      set_cnt(rows[i].ce, rows[i].co);
      wr(poc_pkg::ADDR_CFG0, rows[i].ind);
      wr(poc_pkg::ADDR_CFG1, 8'h80 | rows[i].pol);
      wr(poc_pkg::ADDR_CFG2, rows[i].msk);
      wr(poc_pkg::ADDR_CFG3, rows[i].swp);
      outc($sformatf("outputs row %0d", i), rows[i].exp);
    end
    wr(poc_pkg::ADDR_CFG0, 8'h07);
    wr(poc_pkg::ADDR_CFG1, 8'h80);
    wr(poc_pkg::ADDR_CFG2, 8'h00);
    // bit 2 picks the wait stop, bit 1 the freeze stop, bit 0 which chip mode is entered
    for (int j = 0; j < 8; j++) begin
      wr(poc_pkg::ADDR_CFG3, {j[2], j[1], 6'h00});
      @(posedge clk);
      wait_mode <= ~j[0];
      freeze_mode <= j[0];
      outc("low power", (j[0] ? j[1] : j[2]) ? 8'h00 : 8'h3F);
      @(posedge clk);
      wait_mode <= 1'b0;
      freeze_mode <= 1'b0;
      outc("resumed", 8'h3F);
    end
    wr(poc_pkg::ADDR_CFG0, 8'h81);
    rdc("lock set", poc_pkg::ADDR_CFG0, 8'h81);
    wr(poc_pkg::ADDR_CFG0, 8'h06);
    rdc("cfg0 locked", poc_pkg::ADDR_CFG0, 8'h81);
    wr(poc_pkg::ADDR_CFG1, 8'h15);
    rdc("cfg1 locked", poc_pkg::ADDR_CFG1, 8'h80);
    wr(poc_pkg::ADDR_CFG2, 8'h2A);
    rdc("cfg2 after lock", poc_pkg::ADDR_CFG2, 8'h2A);
    wr(poc_pkg::ADDR_CFG3, 8'h01);
    rdc("cfg3 after lock", poc_pkg::ADDR_CFG3, 8'h01);
    do_reset();
    rdc("lock released", poc_pkg::ADDR_CFG0, 8'h00);
    wr(poc_pkg::ADDR_CFG1, 8'h15);
    rdc("cfg1 writable", poc_pkg::ADDR_CFG1, 8'h15);
    test_done();
  end
endmodule : pwm_output_config_tb
`default_nettype wire

/* verilog/poc_pair_stage.sv */
// one channel pair: compare, complement, exchange, zero-duty force, polarity
`timescale 1ns/100ps
`default_nettype none
module poc_pair_stage (
  input wire logic [poc_pkg::DW-1:0] cnt_top,
  input wire logic [poc_pkg::DW-1:0] cnt_bot,
  input wire logic [poc_pkg::DW-1:0] val_top,
  input wire logic [poc_pkg::DW-1:0] val_bot,
  input wire logic independent,
  input wire logic exchange,
  input wire logic [1:0] zero_force,
  input wire logic [1:0] invert,
  output logic out_top,
  output logic out_bot
);
  function automatic logic active_phase(input logic [poc_pkg::DW-1:0] cnt, input logic [poc_pkg::DW-1:0] val);
    active_phase = (cnt <= val);
  endfunction : active_phase

  logic top_cmp;
  logic bot_cmp;
  logic top_raw;
  logic bot_raw;
  logic do_exchange;

  assign top_cmp = active_phase(cnt_top, val_top);
  assign bot_cmp = independent ? active_phase(cnt_bot, val_bot) : !top_cmp;
  // exchange has no meaning for two unrelated independent channels
  assign do_exchange = exchange && !independent;
  assign top_raw = (do_exchange ? bot_cmp : top_cmp) && !zero_force[0];
  assign bot_raw = (do_exchange ? top_cmp : bot_cmp) && !zero_force[1];
  // masking plus inversion may raise both sides; left to software
  assign out_top = top_raw ^ invert[0];
  assign out_bot = bot_raw ^ invert[1];
endmodule : poc_pair_stage
`default_nettype wire

/* verilog/poc_pkg.sv */
// shared constants and types for the pwm output configuration stage
package poc_pkg;
  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int NCH = 6;
  localparam int NPAIR = 3;
  localparam int IW = 3;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_CFG0 = 8'h00;
  localparam logic [AW-1:0] ADDR_CFG1 = 8'h01;
  localparam logic [AW-1:0] ADDR_CFG2 = 8'h02;
  localparam logic [AW-1:0] ADDR_CFG3 = 8'h03;
  localparam logic [AW-1:0] ADDR_VAL0 = 8'h10;
  localparam logic [AW-1:0] ADDR_VAL5 = 8'h15;

  // ---------------------------------------------------------------------------
  // field positions and writable masks
  // ---------------------------------------------------------------------------
  localparam int LOCK_BIT = 7;
  localparam int ACCEL_BIT = 7;
  localparam int WAIT_BIT = 7;
  localparam int FRZ_BIT = 6;
  localparam int VLM_HI = 4;
  localparam int VLM_LO = 3;
  localparam logic [DW-1:0] CFG0_PROT_MASK = 8'h07;
  localparam logic [DW-1:0] CFG1_MASK = 8'hBF;
  localparam logic [DW-1:0] CFG2_MASK = 8'h3F;
  localparam logic [DW-1:0] CFG3_OPEN_MASK = 8'hC0;
  localparam logic [DW-1:0] CFG3_ACCEL_MASK = 8'h1F;
  localparam logic [DW-1:0] RST_VAL = 8'h00;

  // ---------------------------------------------------------------------------
  // value load modes and levels
  // ---------------------------------------------------------------------------
  localparam logic [1:0] VLM_ALL = 2'h1;
  localparam logic [1:0] VLM_FIRST4 = 2'h2;
  localparam logic [NCH-1:0] WMASK_NONE = 6'h00;
  localparam logic [NCH-1:0] WMASK_ALL = 6'h3E;
  localparam logic [NCH-1:0] WMASK_FIRST4 = 6'h0E;
  localparam logic INACTIVE_LVL = 1'b0;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } poc_bus_req_t;

  typedef logic [NCH-1:0][DW-1:0] poc_word_array_t;
endpackage : poc_pkg

/* verilog/poc_value_store.sv */
// six pulse-width value words with registered read port
`timescale 1ns/100ps
`default_nettype none
module poc_value_store (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [poc_pkg::NCH-1:0] wr_en,
  input wire logic [poc_pkg::DW-1:0] wdata,
  input wire logic rd_en,
  input wire logic [poc_pkg::IW-1:0] rd_idx,
  output logic [poc_pkg::DW-1:0] rd_data,
  output poc_pkg::poc_word_array_t words
);
  poc_pkg::poc_word_array_t words_r;

  assign words = words_r;

  always_ff @(posedge clk) begin
    for (int i = 0; i < poc_pkg::NCH; i++) begin
      if (!rst_b) begin
        words_r[i] <= poc_pkg::RST_VAL;
      end else if (wr_en[i]) begin
        words_r[i] <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= poc_pkg::RST_VAL;
    end else if (rd_en) begin
      rd_data <= words_r[rd_idx];
    end
  end
endmodule : poc_value_store
`default_nettype wire

/* verilog/pwm_output_config.sv */
// output configuration stage of a six-channel, three-pair pwm module
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pwm_output_config (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [poc_pkg::AW-1:0] addr,
  input wire logic [poc_pkg::DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [poc_pkg::DW-1:0] rdata,
  input wire poc_pkg::poc_word_array_t cnt,
  input wire logic wait_mode,
  input wire logic freeze_mode,
  output logic [poc_pkg::NCH-1:0] pwm_out
);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [poc_pkg::DW-1:0] merge(input logic [poc_pkg::DW-1:0] old_v,
                                                   input logic [poc_pkg::DW-1:0] new_v,
                                                   input logic [poc_pkg::DW-1:0] msk);
    merge = (old_v & ~msk) | (new_v & msk);
  endfunction : merge

  function automatic logic [poc_pkg::NCH-1:0] fan_mask(input logic [1:0] mode);
    case (mode)
      poc_pkg::VLM_ALL: fan_mask = poc_pkg::WMASK_ALL;
      poc_pkg::VLM_FIRST4: fan_mask = poc_pkg::WMASK_FIRST4;
      default: fan_mask = poc_pkg::WMASK_NONE;
    endcase
  endfunction : fan_mask

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  poc_pkg::poc_bus_req_t req;
  logic [poc_pkg::DW-1:0] cfg0_r;
  logic [poc_pkg::DW-1:0] cfg1_r;
  logic [poc_pkg::DW-1:0] cfg2_r;
  logic [poc_pkg::DW-1:0] cfg3_r;
  logic [poc_pkg::DW-1:0] cfg0_nxt;
  logic [poc_pkg::DW-1:0] cfg0_merged;
  logic [poc_pkg::DW-1:0] cfg1_nxt;
  logic [poc_pkg::DW-1:0] cfg3_nxt;
  logic [poc_pkg::DW-1:0] cfg3_wmask;
  logic [poc_pkg::DW-1:0] reg_rd_r;
  logic [poc_pkg::DW-1:0] reg_rd_nxt;
  logic [poc_pkg::DW-1:0] val_rd;
  logic [poc_pkg::NCH-1:0] val_wr_en;
  logic [poc_pkg::NCH-1:0] val_onehot;
  logic [poc_pkg::IW-1:0] val_idx;
  logic [poc_pkg::NCH-1:0] pair_out;
  logic [poc_pkg::NCH-1:0] pwm_out_r;
  logic hit_cfg0;
  logic hit_cfg1;
  logic hit_cfg2;
  logic hit_cfg3;
  logic hit_val;
  logic lock_r;
  logic accel;
  logic stop;
  logic sel_val_r;
  poc_pkg::poc_word_array_t words;

  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
  assign hit_cfg0 = (req.addr == poc_pkg::ADDR_CFG0);
  assign hit_cfg1 = (req.addr == poc_pkg::ADDR_CFG1);
  assign hit_cfg2 = (req.addr == poc_pkg::ADDR_CFG2);
  assign hit_cfg3 = (req.addr == poc_pkg::ADDR_CFG3);
  assign hit_val = (req.addr >= poc_pkg::ADDR_VAL0) && (req.addr <= poc_pkg::ADDR_VAL5);
  assign val_idx = poc_pkg::IW'(req.addr - poc_pkg::ADDR_VAL0);
  assign lock_r = cfg0_r[poc_pkg::LOCK_BIT];
  assign accel = cfg1_r[poc_pkg::ACCEL_BIT];

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  // lock bit can only be raised; pair mode bits frozen by it
  assign cfg0_merged = lock_r ? cfg0_r : merge(cfg0_r, req.wdata, poc_pkg::CFG0_PROT_MASK);
  assign cfg0_nxt = {cfg0_r[poc_pkg::LOCK_BIT] | req.wdata[poc_pkg::LOCK_BIT],
                     cfg0_merged[poc_pkg::LOCK_BIT-1:0]};
  // whole register ignores writes after lock, reads unaffected
  assign cfg1_nxt = lock_r ? cfg1_r : (req.wdata & poc_pkg::CFG1_MASK);
  assign cfg3_wmask = accel ? (poc_pkg::CFG3_OPEN_MASK | poc_pkg::CFG3_ACCEL_MASK)
                            : poc_pkg::CFG3_OPEN_MASK;
  assign cfg3_nxt = merge(cfg3_r, req.wdata, cfg3_wmask);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg0_r <= poc_pkg::RST_VAL;
      cfg1_r <= poc_pkg::RST_VAL;
      cfg2_r <= poc_pkg::RST_VAL;
      cfg3_r <= poc_pkg::RST_VAL;
    end else if (req.wr) begin
      if (hit_cfg0) cfg0_r <= cfg0_nxt;
      if (hit_cfg1) cfg1_r <= cfg1_nxt;
      if (hit_cfg2) cfg2_r <= req.wdata & poc_pkg::CFG2_MASK;
      if (hit_cfg3) cfg3_r <= cfg3_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // value words with broadcast load
  // ---------------------------------------------------------------------------
  assign val_onehot = poc_pkg::NCH'(1) << val_idx;
  // a write to word zero fans out per the load mode field
  assign val_wr_en = (req.wr && hit_val) ?
                     (val_onehot | (val_onehot[0] ? fan_mask(cfg3_r[poc_pkg::VLM_HI:poc_pkg::VLM_LO])
                                                  : poc_pkg::WMASK_NONE)) : poc_pkg::WMASK_NONE;

  poc_value_store u_store (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(val_wr_en),
    .wdata(req.wdata),
    .rd_en(req.rd && hit_val),
    .rd_idx(val_idx),
    .rd_data(val_rd),
    .words(words)
  );

  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  // unmapped offsets answer zero, value words come from the store
  assign reg_rd_nxt = hit_cfg0 ? cfg0_r :
                      hit_cfg1 ? cfg1_r :
                      hit_cfg2 ? cfg2_r :
                      hit_cfg3 ? cfg3_r : poc_pkg::RST_VAL;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rd_r <= poc_pkg::RST_VAL;
      sel_val_r <= 1'b0;
    end else if (req.rd) begin
      reg_rd_r <= reg_rd_nxt;
      sel_val_r <= hit_val;
    end
  end

  assign rdata = sel_val_r ? val_rd : reg_rd_r;

  // ---------------------------------------------------------------------------
  // pair stages
  // ---------------------------------------------------------------------------
  for (genvar p = 0; p < poc_pkg::NPAIR; p++) begin : g_pair
    poc_pair_stage u_pair (
      .cnt_top(cnt[2*p]),
      .cnt_bot(cnt[2*p+1]),
      .val_top(words[2*p]),
      .val_bot(words[2*p+1]),
      .independent(cfg0_r[p]),
      .exchange(cfg3_r[p]),
      .zero_force(cfg2_r[2*p+1:2*p]),
      .invert(cfg1_r[2*p+1:2*p]),
      .out_top(pair_out[2*p]),
      .out_bot(pair_out[2*p+1])
    );
  end

  // ---------------------------------------------------------------------------
  // low-power stop and output register
  // ---------------------------------------------------------------------------
  // generators keep running; only the pins are held inactive
  assign stop = (wait_mode && cfg3_r[poc_pkg::WAIT_BIT]) ||
                (freeze_mode && cfg3_r[poc_pkg::FRZ_BIT]);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwm_out_r <= {poc_pkg::NCH{poc_pkg::INACTIVE_LVL}};
    end else begin
      pwm_out_r <= stop ? {poc_pkg::NCH{poc_pkg::INACTIVE_LVL}} : pair_out;
    end
  end

  assign pwm_out = pwm_out_r;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic cmp0;
  logic plain0;
  assign cmp0 = (cnt[0] <= words[0]);
  assign plain0 = cfg0_r[0] && !cfg2_r[0] && !stop;

  // ---------------------------------------------------------------------------
  // reference pin levels
  // ---------------------------------------------------------------------------
  // rebuilt pin by pin from the rules so the pair stages are checked, not copied
  logic [poc_pkg::NCH-1:0] ref_pin;

  for (genvar p = 0; p < poc_pkg::NPAIR; p++) begin : g_ref
    logic top_le;
    logic bot_le;
    logic cpl;
    logic top_lvl;
    logic bot_lvl;
    assign top_le = (cnt[2*p] <= words[2*p]);
    assign bot_le = (cnt[2*p+1] <= words[2*p+1]);
    assign cpl = !cfg0_r[p];
    // complementary: bottom is the inverse of top, exchange swaps the pins
    assign top_lvl = cpl ? (cfg3_r[p] ? !top_le : top_le) : top_le;
    assign bot_lvl = cpl ? (cfg3_r[p] ? top_le : !top_le) : bot_le;
    assign ref_pin[2*p] = (top_lvl && !cfg2_r[2*p]) ^ cfg1_r[2*p];
    assign ref_pin[2*p+1] = (bot_lvl && !cfg2_r[2*p+1]) ^ cfg1_r[2*p+1];
  end

  lock_sticky_a: assert property (lock_r |=> lock_r[*8])
    else $error("write lock dropped without reset");

  cfg1_frozen_a: assert property (lock_r && req.wr && hit_cfg1 |=> $stable(cfg1_r))
    else $error("locked register changed on write");

  accel_gate_a: assert property (req.wr && hit_cfg3 && !accel
    |=> cfg3_r[4:0] == $past(cfg3_r[4:0]) && cfg3_r[7:6] == $past(req.wdata[7:6]))
    else $error("gated bits changed or open bits missed");

  mask_write_a: assert property (req.wr && hit_cfg2 |=> cfg2_r[5:0] == $past(req.wdata[5:0]))
    else $error("mask register did not take write");

  wait_stop_a: assert property (wait_mode && cfg3_r[poc_pkg::WAIT_BIT] |=> pwm_out == '0)
    else $error("outputs active in wait with stop set");

  freeze_stop_a: assert property (freeze_mode && cfg3_r[poc_pkg::FRZ_BIT] |=> pwm_out == '0)
    else $error("outputs active in freeze with stop set");

  pos_pol_a: assert property (plain0 && !cfg1_r[0] |=> pwm_out[0] == $past(cmp0))
    else $error("positive polarity output wrong");

  neg_pol_a: assert property (plain0 && cfg1_r[0] |=> pwm_out[0] == !$past(cmp0))
    else $error("negative polarity output wrong");

  mask_zero_a: assert property (cfg2_r[0] && !cfg1_r[0] ##1 1 |-> !pwm_out[0])
    else $error("masked channel not held low");

  broadcast_a: assert property (req.wr && hit_val && val_idx == '0 && cfg3_r[4:3] == poc_pkg::VLM_ALL
    |=> words[5] == $past(req.wdata) && words[1] == $past(req.wdata))
    else $error("broadcast load missed a word");

  swap_a: assert property (!cfg0_r[0] && cfg3_r[0] && cfg2_r[1:0] == '0 && cfg1_r[1:0] == '0 && !stop
    |=> pwm_out[1] == $past(cmp0) && pwm_out[0] == !$past(cmp0))
    else $error("complementary exchange wrong");

  ref_pins_a: assert property (!stop |=> pwm_out == $past(ref_pin))
    else $error("pin levels differ from the reference");

  run_wait_a: assert property (wait_mode && !stop |=> pwm_out == $past(ref_pin))
    else $error("outputs stopped in wait with stop clear");

  run_freeze_a: assert property (freeze_mode && !stop |=> pwm_out == $past(ref_pin))
    else $error("outputs stopped in freeze with stop clear");

  lock_set_a: assert property (req.wr && hit_cfg0 && req.wdata[poc_pkg::LOCK_BIT] |=> lock_r)
    else $error("write lock not raised");

  lock_keep_a: assert property (lock_r && req.wr && hit_cfg0
    |=> (cfg0_r & poc_pkg::CFG0_PROT_MASK) == ($past(cfg0_r) & poc_pkg::CFG0_PROT_MASK))
    else $error("locked pair mode bits changed");

  mode_write_a: assert property (!lock_r && req.wr && hit_cfg0
    |=> (cfg0_r & poc_pkg::CFG0_PROT_MASK) == ($past(req.wdata) & poc_pkg::CFG0_PROT_MASK))
    else $error("pair mode bits did not take write");

  cfg1_take_a: assert property (!lock_r && req.wr && hit_cfg1
    |=> cfg1_r == ($past(req.wdata) & poc_pkg::CFG1_MASK))
    else $error("open polarity register did not take write");

  accel_open_a: assert property (req.wr && hit_cfg3 && accel
    |=> cfg3_r == ($past(req.wdata) & (poc_pkg::CFG3_OPEN_MASK | poc_pkg::CFG3_ACCEL_MASK)))
    else $error("enabled write to load and exchange bits lost");

  first4_load_a: assert property (req.wr && hit_val && val_idx == '0 && cfg3_r[4:3] == poc_pkg::VLM_FIRST4
    |=> words[3] == $past(req.wdata) && words[5:4] == $past(words[5:4]))
    else $error("partial broadcast load wrong");

  single_load_a: assert property (req.wr && hit_val && val_idx == '0 && fan_mask(cfg3_r[4:3]) == '0
    |=> words[0] == $past(req.wdata) && words[5:1] == $past(words[5:1]))
    else $error("independent load touched other words");

  value_write_a: assert property (req.wr && hit_val && val_idx != '0
    |=> words[$past(val_idx)] == $past(req.wdata))
    else $error("single value word not written");

  value_read_a: assert property (req.rd && hit_val |=> rdata == $past(words[val_idx]))
    else $error("value word read wrong");

  cfg0_read_a: assert property (req.rd && hit_cfg0 |=> rdata == $past(cfg0_r))
    else $error("mode register read wrong");

  cfg1_read_a: assert property (req.rd && hit_cfg1 |=> rdata == $past(cfg1_r))
    else $error("polarity register read wrong");

  cfg2_read_a: assert property (req.rd && hit_cfg2 |=> rdata == $past(cfg2_r))
    else $error("mask register read wrong");

  cfg3_read_a: assert property (req.rd && hit_cfg3 |=> rdata == $past(cfg3_r))
    else $error("load and stop register read wrong");

  unmapped_read_a: assert property (req.rd && !(hit_cfg0 || hit_cfg1 || hit_cfg2 || hit_cfg3 || hit_val)
    |=> rdata == poc_pkg::RST_VAL)
    else $error("unmapped offset read not zero");

  reserved_zero_a: assert property (cfg1_r == (cfg1_r & poc_pkg::CFG1_MASK) && cfg2_r == (cfg2_r & poc_pkg::CFG2_MASK)
    && cfg3_r == (cfg3_r & (poc_pkg::CFG3_OPEN_MASK | poc_pkg::CFG3_ACCEL_MASK)))
    else $error("reserved bit set");

  quiet_bus_a: assert property (!req.wr
    |=> $stable(cfg0_r) && $stable(cfg1_r) && $stable(cfg2_r) && $stable(cfg3_r) && $stable(words))
    else $error("state changed without a write");

  reset_clear_a: assert property ($rose(rst_b)
    |-> pwm_out == '0 && rdata == '0 && !lock_r && words == '0)
    else $error("state not cleared by reset");

  lock_c: cover property (lock_r && req.wr && hit_cfg1);
  bcast_c: cover property (req.wr && hit_val && val_idx == '0 && cfg3_r[4:3] == poc_pkg::VLM_FIRST4);
  stop_c: cover property (stop ##1 !stop);
  swap_c: cover property (!cfg0_r[1] && cfg3_r[1]);
  accel_c: cover property (req.wr && hit_cfg3 && !accel);
endmodule : pwm_output_config
`default_nettype wire
